// >>> rtl/output_channel_divider_config.sv
`timescale 1ns/1ps
module output_channel_divider_config #(
  parameter bit LOW_VCO = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  input  wire logic        cfg_write,
  input  wire logic        cfg_read,
  output logic [15:0]      cfg_rdata,
  output logic             cfg_rvalid,
  output logic             pair_b_clk_out,
  output logic             chan_four_pos_out,
  output logic             chan_four_neg_out,
  output logic             chan_four_diff_out,
  output logic [1:0]       chan_four_source_select,
  output logic [1:0]       chan_four_driver_type,
  output logic             chan_four_edge_rate,
  output logic             chan_four_supply_select,
  output logic             chan_four_prescale_reserved,
  output logic             chan_four_running
);

  localparam int RW = out_div_pkg::RATIO_W;
  localparam int FW = out_div_pkg::FRAC_W;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [RW-1:0] ratio_of(input logic [7:0] v);
    ratio_of = RW'(v) + RW'(1);
  endfunction

  function automatic logic [1:0] prescale_count(input logic [2:0] code,
                                                input logic       low_vco);
    if (code == out_div_pkg::PRESCALE_DIV2) begin
      prescale_count = out_div_pkg::PRESCALE_CNT2;
    end else if (code == out_div_pkg::PRESCALE_DIV3) begin
      prescale_count = out_div_pkg::PRESCALE_CNT3;
    end else if (code == out_div_pkg::PRESCALE_DIV1 && low_vco) begin
      prescale_count = out_div_pkg::PRESCALE_CNT1;
    end else begin
      prescale_count = 2'h0;
    end
  endfunction

  function automatic out_div_pkg::source_t source_of(input logic [1:0] c);
    if (c == 2'h1) begin
      source_of = out_div_pkg::SRC_PRIMARY;
    end else if (c == 2'h2) begin
      source_of = out_div_pkg::SRC_SECONDARY;
    end else begin
      source_of = out_div_pkg::SRC_SYNTH;
    end
  endfunction

  function automatic out_div_pkg::driver_t driver_of(input logic [1:0] c);
    if (c == 2'h2) begin
      driver_of = out_div_pkg::DRV_LVCMOS;
    end else if (c == 2'h3) begin
      driver_of = out_div_pkg::DRV_HCSL;
    end else begin
      driver_of = out_div_pkg::DRV_LVDS;
    end
  endfunction

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [15:0] pair_b_div_q;
  logic [15:0] ch4_ctrl_q;
  logic [15:0] ch4_int_frac_q;
  logic [15:0] ch4_frac_low_q;

  // Stored whole, reserved bits included, so reads echo writes
  always_ff @(posedge clk) begin
    if (reset) begin
      pair_b_div_q   <= out_div_pkg::PAIR_B_DIV_RST;
      ch4_ctrl_q     <= out_div_pkg::CH4_CTRL_RST;
      ch4_int_frac_q <= out_div_pkg::CH4_INT_FRAC_RST;
      ch4_frac_low_q <= out_div_pkg::CH4_FRAC_LOW_RST;
    end else if (cfg_write) begin
      if (cfg_addr == out_div_pkg::PAIR_B_DIV_OFF) begin
        pair_b_div_q <= cfg_wdata;
      end else if (cfg_addr == out_div_pkg::CH4_CTRL_OFF) begin
        ch4_ctrl_q <= cfg_wdata;
      end else if (cfg_addr == out_div_pkg::CH4_INT_FRAC_OFF) begin
        ch4_int_frac_q <= cfg_wdata;
      end else if (cfg_addr == out_div_pkg::CH4_FRAC_LOW_OFF) begin
        ch4_frac_low_q <= cfg_wdata;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [15:0] rdata_q;
  logic        rvalid_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q  <= out_div_pkg::READ_IDLE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_read;
      if (!cfg_read) begin
        rdata_q <= out_div_pkg::READ_IDLE;
      end else if (cfg_addr == out_div_pkg::PAIR_B_DIV_OFF) begin
        rdata_q <= pair_b_div_q;
      end else if (cfg_addr == out_div_pkg::CH4_CTRL_OFF) begin
        rdata_q <= ch4_ctrl_q;
      end else if (cfg_addr == out_div_pkg::CH4_INT_FRAC_OFF) begin
        rdata_q <= ch4_int_frac_q;
      end else if (cfg_addr == out_div_pkg::CH4_FRAC_LOW_OFF) begin
        rdata_q <= ch4_frac_low_q;
      end else begin
        rdata_q <= out_div_pkg::READ_IDLE;
      end
    end
  end

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  logic [7:0]    pair_b_integer_divide;
  logic [1:0]    src_code;
  logic [2:0]    chan_four_prescale;
  logic          chan_four_fractional_enable;
  logic          edge_rate_bit;
  logic          chan_four_neg_side_enable;
  logic          chan_four_pos_side_enable;
  logic [1:0]    drv_code;
  logic [1:0]    chan_four_output_mode;
  logic          supply_bit;
  logic [7:0]    chan_four_integer_divide;
  logic [FW-1:0] chan_four_fraction_value;

  assign pair_b_integer_divide =
    pair_b_div_q[out_div_pkg::PAIR_B_DIV_LSB +: out_div_pkg::INT_DIV_W];
  assign src_code = ch4_ctrl_q[out_div_pkg::SRC_LSB +: 2];
  assign chan_four_prescale =
    ch4_ctrl_q[out_div_pkg::PRESCALE_LSB +: out_div_pkg::PRESCALE_W];
  assign chan_four_fractional_enable =
    ch4_ctrl_q[out_div_pkg::FRAC_EN_BIT];
  assign edge_rate_bit = ch4_ctrl_q[out_div_pkg::EDGE_RATE_BIT];
  assign chan_four_neg_side_enable = ch4_ctrl_q[out_div_pkg::NEG_EN_BIT];
  assign chan_four_pos_side_enable = ch4_ctrl_q[out_div_pkg::POS_EN_BIT];
  assign drv_code = ch4_ctrl_q[out_div_pkg::DRIVER_LSB +: 2];
  assign chan_four_output_mode = ch4_ctrl_q[out_div_pkg::MODE_LSB +: 2];
  assign supply_bit = ch4_ctrl_q[out_div_pkg::SUPPLY_BIT];
  assign chan_four_integer_divide =
    ch4_int_frac_q[out_div_pkg::CH4_INT_LSB +: out_div_pkg::INT_DIV_W];
  assign chan_four_fraction_value = {
    ch4_int_frac_q[out_div_pkg::FRAC_HIGH_LSB +: out_div_pkg::FRAC_HIGH_W],
    ch4_frac_low_q[out_div_pkg::FRAC_LOW_W-1:0]
  };

  // ****************************************************************
  // Pair B divider
  // ****************************************************************
  divider_if #(.W(RW)) pair_b_div ();
  logic pair_b_level_q;

  assign pair_b_div.advance = 1'b1;
  assign pair_b_div.ratio   = ratio_of(pair_b_integer_divide);

  ratio_divider #(.W(RW)) u_pair_b (
    .clk   (clk),
    .reset (reset),
    .d     (pair_b_div)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      pair_b_level_q <= 1'b0;
    end else if (pair_b_div.tick) begin
      pair_b_level_q <= ~pair_b_level_q;
    end
  end

  // ****************************************************************
  // Channel four prescaler
  // ****************************************************************
  logic [1:0] pre_len;
  logic [1:0] pre_cnt_q;
  logic       pre_tick;

  assign pre_len = prescale_count(chan_four_prescale, LOW_VCO);

  always_ff @(posedge clk) begin
    if (reset || !chan_four_fractional_enable || pre_len == 2'h0) begin
      pre_cnt_q <= 2'h0;
    end else if (pre_cnt_q >= pre_len - 2'h1) begin
      pre_cnt_q <= 2'h0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 2'h1;
    end
  end

  // Bypassed unless the fraction is on; reserved code stalls the chain
  always_comb begin
    if (!chan_four_fractional_enable) begin
      pre_tick = 1'b1;
    end else if (pre_len == 2'h0) begin
      pre_tick = 1'b0;
    end else begin
      pre_tick = (pre_cnt_q >= pre_len - 2'h1);
    end
  end

  // ****************************************************************
  // Channel four integer and fractional divider
  // ****************************************************************
  divider_if #(.W(RW)) ch4_div ();
  logic [FW-1:0] frac_acc_q;
  logic          stretch_q;
  logic [FW:0]   frac_sum;

  assign frac_sum = {1'b0, frac_acc_q} + {1'b0, chan_four_fraction_value};
  assign ch4_div.advance = pre_tick;
  assign ch4_div.ratio   = ratio_of(chan_four_integer_divide)
                         + RW'(stretch_q);

  ratio_divider #(.W(RW)) u_ch4 (
    .clk   (clk),
    .reset (reset),
    .d     (ch4_div)
  );

  // Carry out of the accumulator stretches the next period by one
  always_ff @(posedge clk) begin
    if (reset || !chan_four_fractional_enable) begin
      frac_acc_q <= '0;
      stretch_q  <= 1'b0;
    end else if (ch4_div.tick) begin
      frac_acc_q <= frac_sum[FW-1:0];
      stretch_q  <= frac_sum[FW];
    end
  end

  // ****************************************************************
  // Channel four output stage
  // ****************************************************************
  logic ch4_level_q;
  logic ch4_out_level;
  logic cmos_sel;

  always_ff @(posedge clk) begin
    if (reset) begin
      ch4_level_q <= 1'b0;
    end else if (chan_four_output_mode != out_div_pkg::MODE_CLOCK) begin
      ch4_level_q <= 1'b0;
    end else if (ch4_div.tick) begin
      ch4_level_q <= ~ch4_level_q;
    end
  end

  always_comb begin
    case (chan_four_output_mode)
      out_div_pkg::MODE_CLOCK: ch4_out_level = ch4_level_q;
      out_div_pkg::MODE_HIGH:  ch4_out_level = 1'b1;
      default:                 ch4_out_level = 1'b0;
    endcase
  end

  assign cmos_sel = (driver_of(drv_code) == out_div_pkg::DRV_LVCMOS);

  logic pos_q;
  logic neg_q;
  logic diff_q;
  logic run_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pos_q  <= 1'b0;
      neg_q  <= 1'b0;
      diff_q <= 1'b0;
      run_q  <= 1'b0;
    end else begin
      pos_q  <= cmos_sel && chan_four_pos_side_enable
             && ch4_out_level;
      // Negative side needs positive side and a live mode
      neg_q  <= cmos_sel && chan_four_pos_side_enable
             && chan_four_neg_side_enable && !ch4_out_level
             && (|chan_four_output_mode);
      diff_q <= !cmos_sel && ch4_out_level;
      run_q  <= (chan_four_output_mode == out_div_pkg::MODE_CLOCK)
             && (pre_len != 2'h0 || !chan_four_fractional_enable);
    end
  end

  // ****************************************************************
  // Decoded settings
  // ****************************************************************
  logic [1:0] src_q;
  logic [1:0] drv_q;
  logic       edge_q;
  logic       supply_q;
  logic       pre_rsv_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      src_q     <= out_div_pkg::SRC_SYNTH;
      drv_q     <= out_div_pkg::DRV_LVDS;
      edge_q    <= 1'b0;
      supply_q  <= 1'b0;
      pre_rsv_q <= 1'b0;
    end else begin
      src_q     <= source_of(src_code);
      drv_q     <= driver_of(drv_code);
      edge_q    <= edge_rate_bit;
      supply_q  <= supply_bit;
      pre_rsv_q <= chan_four_fractional_enable
                && (pre_len == 2'h0);
    end
  end

  assign cfg_rdata                   = rdata_q;
  assign cfg_rvalid                  = rvalid_q;
  assign pair_b_clk_out              = pair_b_level_q;
  assign chan_four_pos_out           = pos_q;
  assign chan_four_neg_out           = neg_q;
  assign chan_four_diff_out          = diff_q;
  assign chan_four_source_select     = src_q;
  assign chan_four_driver_type       = drv_q;
  assign chan_four_edge_rate         = edge_q;
  assign chan_four_supply_select     = supply_q;
  assign chan_four_prescale_reserved = pre_rsv_q;
  assign chan_four_running           = run_q;

endmodule

// >>> shared/out_div_pkg.sv
package out_div_pkg;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam int         ADDR_W            = 4;
  localparam int         DATA_W            = 16;
  localparam logic [3:0] PAIR_B_DIV_OFF    = 4'h8;
  localparam logic [3:0] CH4_CTRL_OFF      = 4'h9;
  localparam logic [3:0] CH4_INT_FRAC_OFF  = 4'hA;
  localparam logic [3:0] CH4_FRAC_LOW_OFF  = 4'hB;
  localparam logic [15:0] PAIR_B_DIV_RST   = 16'h0000;
  localparam logic [15:0] CH4_CTRL_RST     = 16'h0000;
  localparam logic [15:0] CH4_INT_FRAC_RST = 16'h0000;
  localparam logic [15:0] CH4_FRAC_LOW_RST = 16'h0000;
  localparam logic [15:0] READ_IDLE        = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PAIR_B_DIV_LSB = 0;
  localparam int INT_DIV_W      = 8;
  localparam int SRC_LSB        = 13;
  localparam int PRESCALE_LSB   = 10;
  localparam int PRESCALE_W     = 3;
  localparam int FRAC_EN_BIT    = 9;
  localparam int EDGE_RATE_BIT  = 8;
  localparam int NEG_EN_BIT     = 7;
  localparam int POS_EN_BIT     = 6;
  localparam int DRIVER_LSB     = 3;
  localparam int MODE_LSB       = 1;
  localparam int SUPPLY_BIT     = 0;
  localparam int CH4_INT_LSB    = 4;
  localparam int FRAC_HIGH_LSB  = 0;
  localparam int FRAC_HIGH_W    = 4;
  localparam int FRAC_LOW_W     = 16;
  localparam int FRAC_W         = 20;
  localparam int RATIO_W        = 10;

  // ****************************************************************
  // Codes and decoded types
  // ****************************************************************
  localparam logic [2:0] PRESCALE_DIV2 = 3'h0;
  localparam logic [2:0] PRESCALE_DIV3 = 3'h1;
  localparam logic [2:0] PRESCALE_DIV1 = 3'h7;
  localparam logic [1:0] PRESCALE_CNT2 = 2'h2;
  localparam logic [1:0] PRESCALE_CNT3 = 2'h3;
  localparam logic [1:0] PRESCALE_CNT1 = 2'h1;

  typedef enum logic [1:0] {
    SRC_SYNTH     = 2'h0,
    SRC_PRIMARY   = 2'h1,
    SRC_SECONDARY = 2'h2
  } source_t;

  typedef enum logic [1:0] {
    DRV_LVDS   = 2'h0,
    DRV_LVCMOS = 2'h2,
    DRV_HCSL   = 2'h3
  } driver_t;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_CLOCK  = 2'h1,
    MODE_LOW    = 2'h2,
    MODE_HIGH   = 2'h3
  } mode_t;

endpackage

// >>> shared/divider_if.sv
`timescale 1ns/1ps
interface divider_if #(
  parameter int W = 10
);
  logic         advance;
  logic [W-1:0] ratio;
  logic         tick;

  modport ctl (output advance, output ratio, input tick);
  modport div (input advance, input ratio, output tick);
endinterface

// >>> rtl/ratio_divider.sv
`timescale 1ns/1ps
module ratio_divider #(
  parameter int W = 10
) (
  input  wire logic   clk,
  input  wire logic   reset,
  divider_if.div      d
);

  logic [W-1:0] cnt_q;
  logic         tick_q;

  // ****************************************************************
  // Count advance pulses, one tick per ratio pulses
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (d.advance) begin
        // Compare with >= so a shrunk ratio never runs away
        if (cnt_q >= d.ratio - W'(1)) begin
          cnt_q  <= '0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + W'(1);
        end
      end
    end
  end

  assign d.tick = tick_q;

endmodule

// >>> verif/div_cfg_checker.sv
`timescale 1ns/1ps
module div_cfg_checker #(
  parameter bit LOW_VCO = 1'b0
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic        cfg_write,
  input wire logic        cfg_read,
  input wire logic [15:0] cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire logic        pair_b_clk_out,
  input wire logic        chan_four_pos_out,
  input wire logic        chan_four_neg_out,
  input wire logic        chan_four_diff_out,
  input wire logic [1:0]  chan_four_source_select,
  input wire logic [1:0]  chan_four_driver_type,
  input wire logic        chan_four_edge_rate,
  input wire logic        chan_four_supply_select,
  input wire logic        chan_four_prescale_reserved,
  input wire logic        chan_four_running
);
  // ************************************************************
  // Shadow of control and divider registers
  // ************************************************************
  logic [15:0] ctl_q;
  logic [7:0]  div_q;
  logic [2:0]  hold_q;
  logic [9:0]  since_q;
  logic        live_q, last_q, seen_q, clean_q, res_e, lvc_e;
  logic [1:0]  src_e, drv_e, mode_e;

  always_comb begin
    src_e = (ctl_q[14:13] == 2'h3) ? 2'h0 : ctl_q[14:13];
    drv_e = (ctl_q[4:3] == 2'h1) ? 2'h0 : ctl_q[4:3];
    mode_e = ctl_q[2:1];
    lvc_e = (ctl_q[4:3] == 2'h2);
    res_e = ctl_q[9] && !(ctl_q[12:11] == 2'h0 ||
                          (ctl_q[12:10] == 3'h7 && LOW_VCO));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_q <= 16'h0000;
      hold_q <= 3'h0;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      if (cfg_write && cfg_addr == 4'h9) begin
        ctl_q <= cfg_wdata;
        hold_q <= 3'h0;
      end else if (hold_q != 3'h7) begin
        hold_q <= hold_q + 3'h1;
      end
    end
  end

  // Interval between toggles, trusted after two toggles past a write
  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= 8'h00;
      last_q <= 1'b0;
      since_q <= 10'h000;
      seen_q <= 1'b0;
      clean_q <= 1'b0;
    end else begin
      last_q <= pair_b_clk_out;
      since_q <= (pair_b_clk_out != last_q) ? 10'h001 : since_q + 10'h001;
      if (cfg_write && cfg_addr == 4'h8) begin
        div_q <= cfg_wdata[7:0];
        seen_q <= 1'b0;
        clean_q <= 1'b0;
      end else if (pair_b_clk_out != last_q) begin
        seen_q <= 1'b1;
        clean_q <= seen_q;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_ctl_read;
    cfg_read && cfg_addr == 4'h9;
  endsequence
  sequence s_settled;
    live_q && hold_q == 3'h7 && mode_e != 2'h1;
  endsequence

  AST_RVALID_PULSE: assert property (cfg_read |=> cfg_rvalid)
    else $error("read strobe gave no valid");
  AST_RDATA_IDLE: assert property (
    !cfg_read |=> !cfg_rvalid && cfg_rdata == 16'h0000)
    else $error("read data not idle");
  AST_CTL_READBACK: assert property (
    s_ctl_read |=> cfg_rdata == $past(ctl_q))
    else $error("control readback wrong");
  AST_SOURCE: assert property (
    live_q |-> chan_four_source_select == $past(src_e))
    else $error("source select wrong");
  AST_DRIVER: assert property (
    live_q |-> chan_four_driver_type == $past(drv_e))
    else $error("driver type wrong");
  AST_EDGE_SUPPLY: assert property (live_q |->
    {chan_four_edge_rate, chan_four_supply_select} ==
    $past({ctl_q[8], ctl_q[0]}))
    else $error("edge rate or supply wrong");
  AST_PRESCALE_FLAG: assert property (
    live_q |-> chan_four_prescale_reserved == $past(res_e))
    else $error("prescale flag wrong");
  AST_RUNNING: assert property (
    live_q |-> chan_four_running == $past(mode_e == 2'h1 && !res_e))
    else $error("running flag wrong");
  AST_NEG_NEEDS_POS: assert property (
    chan_four_neg_out |-> $past(lvc_e && ctl_q[7:6] == 2'h3))
    else $error("negative side without positive side");
  AST_STATIC_LEVEL: assert property (s_settled |->
    chan_four_pos_out == (mode_e == 2'h3 && lvc_e && ctl_q[6]) &&
    chan_four_diff_out == (mode_e == 2'h3 && !lvc_e) &&
    (mode_e == 2'h2 || !chan_four_neg_out))
    else $error("static level wrong");
  AST_PAIR_B_PERIOD: assert property (
    live_q && clean_q && pair_b_clk_out != last_q |->
    since_q == {2'b00, div_q} + 10'h001)
    else $error("pair b toggle interval wrong");
endmodule

bind output_channel_divider_config div_cfg_checker #(.LOW_VCO(LOW_VCO)) chk (
  .clk(clk), .reset(reset), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
  .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .pair_b_clk_out(pair_b_clk_out),
  .chan_four_pos_out(chan_four_pos_out),
  .chan_four_neg_out(chan_four_neg_out),
  .chan_four_diff_out(chan_four_diff_out),
  .chan_four_source_select(chan_four_source_select),
  .chan_four_driver_type(chan_four_driver_type),
  .chan_four_edge_rate(chan_four_edge_rate),
  .chan_four_supply_select(chan_four_supply_select),
  .chan_four_prescale_reserved(chan_four_prescale_reserved),
  .chan_four_running(chan_four_running));

// >>> verif/output_channel_divider_config_test.sv
`timescale 1ns/1ps
module output_channel_divider_config_test;
  localparam bit LV = 1'b0;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cfg_write = 1'b0;
  logic        cfg_read = 1'b0;
  logic [3:0]  cfg_addr = 4'h0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [15:0] cfg_rdata;
  logic        cfg_rvalid, pair_b, pos, neg, diff, edge_r, supply, res, run;
  logic [1:0]  src, drv;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          regs [4] = '{0, 0, 0, 0};
  logic [31:0] rng = 32'd11465;

  always #2.5 clk = ~clk;

  output_channel_divider_config #(.LOW_VCO(LV)) DUT (
    .clk(clk), .reset(reset), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .pair_b_clk_out(pair_b),
    .chan_four_pos_out(pos), .chan_four_neg_out(neg),
    .chan_four_diff_out(diff), .chan_four_source_select(src),
    .chan_four_driver_type(drv), .chan_four_edge_rate(edge_r),
    .chan_four_supply_select(supply),
    .chan_four_prescale_reserved(res), .chan_four_running(run));

  // ************************************************************
  // Helpers
  // ************************************************************
  function logic [15:0] rand16();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction

  function logic pick(input int sel);
    return (sel == 0) ? pair_b : diff;
  endfunction

  task give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_write = 1'b1;
    @(negedge clk);
    cfg_write = 1'b0;
    if (a[3:2] == 2'b10) regs[a[1:0]] = d;
  endtask

  task rd(input logic [3:0] a);
    logic [15:0] e;
    e = (a[3:2] == 2'b10) ? regs[a[1:0]][15:0] : 16'h0000;
    @(negedge clk);
    cfg_addr = a;
    cfg_read = 1'b1;
    @(negedge clk);
    cfg_read = 1'b0;
    chk(cfg_rvalid, 1'b1);
    chk(cfg_rdata, e);
  endtask

  task measure(input int sel, output int n);
    logic a;
    repeat (3) begin
      a = pick(sel);
      n = 0;
      while (pick(sel) === a && n < 3000) begin
        @(negedge clk);
        n++;
      end
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, cycles, 0);
      give_verdict();
    end
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [15:0] d;
    logic [3:0]  a;
    int          n;
    int          n2;
    logic        r;
    int          mul [3] = '{1, 2, 3};
    repeat (3) @(negedge clk);
    reset = 1'b0;
    for (int i = 7; i < 13; i++) rd(i[3:0]);
    wr(4'h5, 16'hFFFF);
    rd(4'h5);
    $display("test reset_and_unmapped done");
    for (int i = 0; i < 24; i++) begin
      d = rand16();
      a = {2'b10, d[1:0]};
      d = rand16();
      if (a == 4'h8) d = d & 16'h00FF;
      if (a == 4'h9) d = (d & 16'h7FDF) | {9'h000, d[7], 6'h00};
      if (a == 4'hA) d = d & 16'h0FFF;
      wr(a, d);
      rd(a);
    end
    $display("test readback done");
    for (int i = 0; i < 16; i++) begin
      wr(4'h9, {1'b0, i[3:2], 4'h0, i[0], 3'h0, i[1:0], 2'h1, i[1]});
      repeat (2) @(negedge clk);
      chk(src, (i[3:2] == 2'h3) ? 2'h0 : i[3:2]);
      chk(drv, (i[1:0] == 2'h1) ? 2'h0 : i[1:0]);
      chk(edge_r, i[0]);
      chk(supply, i[1]);
    end
    $display("test field_decode done");
    for (int f = 0; f < 2; f++) for (int c = 0; c < 8; c++) begin
      wr(4'h9, {3'h0, c[2:0], f[0], 6'h00, 2'h1, 1'b0});
      r = f[0] && !(c < 2 || (c == 7 && LV));
      repeat (2) @(negedge clk);
      chk(res, r);
      chk(run, !r);
    end
    $display("test prescale done");
    for (int m = 0; m < 4; m++) for (int k = 2; k < 4; k++) begin
      wr(4'h9, {8'h00, 2'b11, 1'b0, k[1:0], m[1:0], 1'b0});
      repeat (3) @(negedge clk);
      if (m != 1) begin
        chk(pos, m == 3 && k == 2);
        chk(diff, m == 3 && k == 3);
        if (m != 2) chk(neg, 1'b0);
      end
    end
    $display("test static_levels done");
    for (int i = 0; i < 3; i++) begin
      wr(4'h8, (i == 0) ? 16'h0000 : (i == 1) ? 16'h0005 : 16'h00FF);
      measure(0, n);
      chk(n, (i == 0) ? 1 : (i == 1) ? 6 : 256);
    end
    wr(4'hB, 16'h0000);
    wr(4'hA, 16'h0020);
    for (int i = 0; i < 3; i++) begin
      wr(4'h9, {3'h0, (i == 0) ? 3'h2 : i[2:0] - 3'h1, i != 0, 9'h002});
      measure(1, n);
      chk(n, 3 * mul[i]);
    end
    wr(4'hA, 16'h0028);
    wr(4'h9, {3'h0, 3'h0, 1'b1, 9'h002});
    measure(1, n);
    measure(1, n2);
    chk(n + n2, 14);
    $display("test periods done");
    give_verdict();
  end
endmodule
